// file: clkdist_pkg.sv
// constants for the output clock distribution block
// assumes source clocks arrive as plain levels sampled by the 25 MHz clock
package clkdist_pkg;
  localparam int NSRC = 7;
  localparam int NDIV = 11;
  localparam int CDW  = 12;
  localparam int SDW  = 20;
  localparam int DLYW = 8;
  // source vector positions
  localparam logic [2:0] SRC_PLL_C   = 3'h0;
  localparam logic [2:0] SRC_PLL_B   = 3'h1;
  localparam logic [2:0] SRC_PLL_A   = 3'h2;
  localparam logic [2:0] SRC_PLL_A2  = 3'h3;
  localparam logic [2:0] SRC_CRYSTAL = 3'h4;
  localparam logic [2:0] SRC_REF     = 3'h5;
  localparam logic [2:0] SRC_OSC_C   = 3'h6;
  localparam logic [1:0] SEL3_OSC_C  = 2'h3;
  // single-ended pin modes
  localparam logic [1:0] POL_TRUE = 2'h0;
  localparam logic [1:0] POL_INV  = 2'h1;
  localparam logic [1:0] POL_HIZ  = 2'h2;
  localparam logic [1:0] POL_LOW  = 2'h3;
  // differential formats
  localparam logic [2:0] FMT_OFF     = 3'h0;
  localparam logic [2:0] FMT_LVPECL  = 3'h1;
  localparam logic [2:0] FMT_HS_DIFF = 3'h2;
  localparam logic [2:0] FMT_LVDS    = 3'h3;
  localparam logic [2:0] FMT_HCSL    = 3'h4;
  // channel to divider map, channel 15 first
  localparam logic [15:0][3:0] CH_DIV = {4'ha, 4'h9, 4'h8, 4'h8, 4'h7, 4'h7, 4'h6, 4'h6,
                                         4'h5, 4'h5, 4'h4, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [10:0] SD_CAP = 11'h7f3;
  // aux select to divider, select 6 first
  localparam logic [6:0][3:0] AUX_DIV = {4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h1, 4'h0};
endpackage

// file: clkdist.sv
// output clock distribution: muxes, dividers, sync, delay, drivers
// assumes PLL clocks are slow enough to be sampled by the 25 MHz clock
`timescale 1ns/1ns
module clkdist (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // source clocks and lock flags, asynchronous
  input  wire logic                  pll_c_clk,
  input  wire logic                  pll_b_clk,
  input  wire logic                  pll_a_clk,
  input  wire logic                  pll_a_sec_clk,
  input  wire logic                  crystal_ref_clk,
  input  wire logic                  ref_in_clk,
  input  wire logic                  osc_c_clk,
  input  wire logic                  pll_a_lock,
  input  wire logic                  pll_b_lock,
  input  wire logic                  pll_c_lock,
  // sync controls
  input  wire logic                  sync_pin,
  input  wire logic                  sync_sw,
  input  wire logic                  sync_master_en,
  input  wire logic [10:0]           div_sync_en,
  // source selection
  input  wire logic [2:0]            sel_ch0,
  input  wire logic [2:0]            sel_ch1,
  input  wire logic [1:0]            sel_ch2_3,
  input  wire logic [1:0]            sel_ch14_15,
  input  wire logic                  sel_ch4_7,
  input  wire logic                  sel_ch8_13,
  input  wire logic                  pll_c_post_bypass,
  // dividers and delays
  input  wire logic [10:0][11:0]     chan_div_value,
  input  wire logic [10:0][19:0]     sysref_div_value,
  input  wire logic [10:0]           sysref_en,
  input  wire logic [10:0][7:0]      static_dly,
  input  wire logic [10:0][7:0]      sysref_dly,
  // drivers
  input  wire logic [15:0][2:0]      out_fmt,
  input  wire logic [15:0]           mute_en,
  input  wire logic [1:0]            cmos_mode,
  input  wire logic [1:0][1:0]       pol_p,
  input  wire logic [1:0][1:0]       pol_n,
  // aux replication
  input  wire logic                  aux_one_en,
  input  wire logic [2:0]            aux_one_sel,
  input  wire logic                  aux_two_en,
  input  wire logic [2:0]            aux_two_sel,
  // outputs
  output logic [15:0]                out_p,
  output logic [15:0]                out_n,
  output logic [15:0]                out_p_oe,
  output logic [15:0]                out_n_oe,
  output logic                       aux_io_one,
  output logic                       aux_io_one_oe,
  output logic                       aux_io_two,
  output logic                       aux_io_two_oe,
  output logic [10:0]                div_pwr_dn
);

  typedef struct packed {
    logic [6:0]            src1;
    logic [6:0]            src2;
    logic [6:0]            src3;
    logic [2:0]            lk1;
    logic [2:0]            lk2;
    logic                  syn1;
    logic                  syn2;
    logic [10:0][11:0]     cnt;
    logic [10:0][19:0]     scnt;
    logic [10:0][7:0]      dly;
    logic [10:0][7:0]      sdly;
    logic [10:0]           cd;
    logic [10:0]           sd;
    logic [10:0]           pd;
    logic [15:0]           op;
    logic [15:0]           on;
    logic [15:0]           oep;
    logic [15:0]           oen;
    logic                  ax1;
    logic                  ax2;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [10:0][2:0] si;
  logic [10:0]      lvl;
  logic [10:0]      edg;
  logic [10:0]      ok;
  logic [10:0]      byp;
  logic [10:0]      rstk;
  logic [10:0]      dv;
  logic             sync_on;

  // high phase of a divide-by-n count
  function automatic logic hi_phase(input logic [19:0] c, input logic [19:0] n);
    logic [20:0] h;
    h = ({1'b0, n} + 21'h1) >> 1;
    return {1'b0, c} < h;
  endfunction

  // next count modulo n
  function automatic logic [19:0] wrap(input logic [19:0] c, input logic [19:0] n);
    return (c >= n - 20'h1) ? 20'h0 : c + 20'h1;
  endfunction

  // lock state of a source
  function automatic logic src_ok(input logic [2:0] s, input logic [2:0] lk);
    case (s)
      clkdist_pkg::SRC_PLL_C, clkdist_pkg::SRC_OSC_C: return lk[2];
      clkdist_pkg::SRC_PLL_B:                         return lk[1];
      clkdist_pkg::SRC_PLL_A, clkdist_pkg::SRC_PLL_A2: return lk[0];
      default:                                         return 1'b1;
    endcase
  endfunction

  // single-ended pin drive, returns {oe, level}
  function automatic logic [1:0] se_drive(input logic [1:0] m, input logic c);
    case (m)
      clkdist_pkg::POL_TRUE: return {1'b1, c};
      clkdist_pkg::POL_INV:  return {1'b1, ~c};
      clkdist_pkg::POL_HIZ:  return 2'b00;
      default:               return 2'b10;
    endcase
  endfunction

  always_comb begin
    logic       act;
    logic       sde;
    logic       cdr;
    logic       cdo;
    logic [1:0] dp;
    logic [1:0] dn;
    logic [3:0] k;
    act = 1'b0;
    sde = 1'b0;
    cdr = 1'b0;
    cdo = 1'b0;
    dp  = 2'b00;
    dn  = 2'b00;
    k   = 4'h0;
    st_d = st_q;
    st_d.src1 = {osc_c_clk, ref_in_clk, crystal_ref_clk, pll_a_sec_clk, pll_a_clk, pll_b_clk, pll_c_clk};
    st_d.src2 = st_q.src1;
    st_d.src3 = st_q.src2;
    st_d.lk1  = {pll_c_lock, pll_b_lock, pll_a_lock};
    st_d.lk2  = st_q.lk1;
    st_d.syn1 = sync_pin;
    st_d.syn2 = st_q.syn1;
    sync_on = sync_master_en & (st_q.syn2 | sync_sw);
    for (int d = 0; d < clkdist_pkg::NDIV; d++) begin
      // source selectors
      if (d < 2) begin
        si[d] = (d == 0) ? sel_ch0 : sel_ch1;
        if (si[d] > clkdist_pkg::SRC_REF) si[d] = clkdist_pkg::SRC_REF;
      end else if (d < 4) begin
        si[d] = (sel_ch2_3 > 2'h2) ? clkdist_pkg::SRC_PLL_A : {1'b0, sel_ch2_3};
      end else if (d < 9) begin
        si[d] = (d < 6) ? {2'b00, sel_ch4_7} : {2'b00, sel_ch8_13};
      end else if (sel_ch14_15 == clkdist_pkg::SEL3_OSC_C) begin
        si[d] = pll_c_post_bypass ? clkdist_pkg::SRC_OSC_C : clkdist_pkg::SRC_PLL_C;
      end else begin
        si[d] = {1'b0, sel_ch14_15};
      end
      lvl[d] = st_q.src2[si[d]];
      edg[d] = st_q.src2[si[d]] & ~st_q.src3[si[d]];
      ok[d]  = src_ok(si[d], st_q.lk2);
      // power-down when no channel of the divider is enabled
      act = 1'b0;
      for (int c = 0; c < 16; c++) begin
        // single-ended driver is off when both pins are hi-z or low
        if (c < 2 && cmos_mode[c]) begin
          if (clkdist_pkg::CH_DIV[c] == d[3:0] && (pol_p[c] < clkdist_pkg::POL_HIZ
              || pol_n[c] < clkdist_pkg::POL_HIZ)) act = 1'b1;
        end else if (clkdist_pkg::CH_DIV[c] == d[3:0] && out_fmt[c] != clkdist_pkg::FMT_OFF) begin
          act = 1'b1;
        end
      end
      st_d.pd[d] = ~act;
      byp[d]  = chan_div_value[d] <= 12'h1;
      rstk[d] = ~act | (sync_on & div_sync_en[d] & ~byp[d]);
      sde = sysref_en[d] & clkdist_pkg::SD_CAP[d];
      cdr = 1'b0;
      if (rstk[d]) begin
        // preload so the first edge starts a full period
        st_d.cnt[d]  = chan_div_value[d] - 12'h1;
        st_d.scnt[d] = sysref_div_value[d] - 20'h1;
        st_d.dly[d]  = '0;
        st_d.sdly[d] = '0;
        st_d.cd[d]   = 1'b0;
        st_d.sd[d]   = 1'b0;
      end else if (edg[d] && st_q.dly[d] < static_dly[d]) begin
        st_d.dly[d] = st_q.dly[d] + 8'h1;
      end else if (edg[d]) begin
        if (byp[d]) begin
          cdr = 1'b1;
        end else begin
          st_d.cnt[d] = 12'(wrap({8'h0, st_q.cnt[d]}, {8'h0, chan_div_value[d]}));
          st_d.cd[d]  = hi_phase({8'h0, st_d.cnt[d]}, {8'h0, chan_div_value[d]});
          cdr = st_d.cd[d] & ~st_q.cd[d];
        end
      end
      // sysref divider clocked by channel divider rises
      if (!rstk[d] && sde && cdr) begin
        if (st_q.sdly[d] < sysref_dly[d]) begin
          st_d.sdly[d] = st_q.sdly[d] + 8'h1;
        end else begin
          st_d.scnt[d] = wrap(st_q.scnt[d], sysref_div_value[d]);
          st_d.sd[d]   = hi_phase(st_d.scnt[d], sysref_div_value[d]);
        end
      end
      cdo = byp[d] ? (lvl[d] & ~rstk[d]) : st_d.cd[d];
      if (sde && sysref_div_value[d] > 20'h1) dv[d] = st_d.sd[d];
      else dv[d] = cdo;
    end
    // output drivers
    for (int c = 0; c < 16; c++) begin
      k = clkdist_pkg::CH_DIV[c];
      if (c < 2 && cmos_mode[c]) begin
        if (mute_en[c] && !ok[k]) begin
          dp = 2'b10;
          dn = 2'b10;
        end else begin
          dp = se_drive(pol_p[c], dv[k]);
          dn = se_drive(pol_n[c], dv[k]);
        end
      end else if (out_fmt[c] == clkdist_pkg::FMT_OFF) begin
        dp = 2'b00;
        dn = 2'b00;
      end else if (mute_en[c] && !ok[k]) begin
        dp = 2'b10;
        dn = 2'b10;
      end else begin
        dp = {1'b1, dv[k]};
        dn = {1'b1, ~dv[k]};
      end
      st_d.oep[c] = dp[1];
      st_d.op[c]  = dp[0];
      st_d.oen[c] = dn[1];
      st_d.on[c]  = dn[0];
    end
    st_d.ax1 = aux_one_en & st_d.sd[clkdist_pkg::AUX_DIV[aux_one_sel > 3'h6 ? 3'h6 : aux_one_sel]];
    st_d.ax2 = aux_two_en & st_d.sd[clkdist_pkg::AUX_DIV[aux_two_sel > 3'h6 ? 3'h6 : aux_two_sel]];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) st_q <= '0;
    else st_q <= st_d;
  end

  assign out_p         = st_q.op;
  assign out_n         = st_q.on;
  assign out_p_oe      = st_q.oep;
  assign out_n_oe      = st_q.oen;
  assign aux_io_one    = st_q.ax1;
  assign aux_io_one_oe = aux_one_en;
  assign aux_io_two    = st_q.ax2;
  assign aux_io_two_oe = aux_two_en;
  assign div_pwr_dn    = st_q.pd;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [12:0] per_q;
  logic        seen_q;
  logic        rise2;
  assign rise2 = st_d.cd[2] & ~st_q.cd[2];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      per_q  <= 13'h0;
      seen_q <= 1'b0;
    end else if (rstk[2] || byp[2]) begin
      per_q  <= 13'h0;
      seen_q <= 1'b0;
    end else if (rise2) begin
      per_q  <= 13'h0;
      seen_q <= 1'b1;
    end else if (edg[2]) begin
      per_q  <= per_q + 13'h1;
    end
  end

  sequence sync_held;
    sync_on && div_sync_en[2] && !byp[2];
  endsequence
  sequence pair_off;
    out_fmt[8] == clkdist_pkg::FMT_OFF && out_fmt[9] == clkdist_pkg::FMT_OFF;
  endsequence

  chk_sync_low_out: assert property (sync_held ##1 sync_held |-> !st_q.cd[2] && !st_q.sd[2])
    else $error("sync-enabled divider not held low");
  chk_bypass_ungated: assert property (byp[4] && !sysref_en[4] && out_fmt[4] != clkdist_pkg::FMT_OFF
      && !mute_en[4] |=> out_p[4] == $past(lvl[4]))
    else $error("bypass output does not follow source");
  chk_pair_pwr_dn: assert property (pair_off ##1 pair_off |-> div_pwr_dn[6] && !out_p_oe[8])
    else $error("pair divider not powered down");
  chk_ch0_pwr_dn: assert property (out_fmt[0] == clkdist_pkg::FMT_OFF && !cmos_mode[0] |=> div_pwr_dn[0])
    else $error("channel 0 divider not powered down");
  chk_diff_only_oe: assert property (out_fmt[2] != clkdist_pkg::FMT_OFF |=> out_p_oe[2] && out_n_oe[2]
      && (mute_en[2] || out_n[2] == !out_p[2]))
    else $error("differential pins not complementary");
  chk_se_hiz_pin: assert property (cmos_mode[0] && pol_n[0] == clkdist_pkg::POL_HIZ && !mute_en[0]
      |=> !out_n_oe[0] && !out_n[0])
    else $error("hi-z pin driven");
  chk_se_low_pin: assert property (cmos_mode[0] && pol_n[0] == clkdist_pkg::POL_LOW
      |=> out_n_oe[0] && !out_n[0])
    else $error("static low pin toggles");
  chk_mute_unlock: assert property (mute_en[3] && !ok[3] && out_fmt[3] != clkdist_pkg::FMT_OFF
      |=> !out_p[3] && !out_n[3])
    else $error("output not muted on unlocked source");
  chk_aux_copy: assert property (aux_one_en && aux_one_sel == 3'h0 |=> aux_io_one == st_q.sd[0])
    else $error("aux pin not replicating sysref");
  chk_div_period: assert property (rise2 && seen_q && !rstk[2] && $stable(chan_div_value[2])
      |-> per_q + 13'h1 == {1'b0, chan_div_value[2]})
    else $error("divider period wrong");

endmodule

// file: clk_receiver.sv
// clock receiver model: measures period and counts rising edges of one pin
// assumes the pin is sampled by the 25 MHz bench clock
`timescale 1ns/1ns
module clk_receiver (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // observed pin
  input  wire logic        pin,
  // measurements
  output logic [15:0]      period,
  output logic [15:0]      rises
);
  typedef struct packed {
    logic        pin;
    logic [15:0] cnt;
    logic [15:0] period;
    logic [15:0] rises;
  } rx_t;
  rx_t rx_q;
  rx_t rx_d;
  always_comb begin
    rx_d = rx_q;
    rx_d.pin = pin;
    rx_d.cnt = rx_q.cnt + 16'h0001;
    if (pin && !rx_q.pin) begin
      rx_d.period = rx_q.cnt;
      rx_d.cnt = 16'h0001;
      rx_d.rises = rx_q.rises + 16'h0001;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end
  assign period = rx_q.period;
  assign rises = rx_q.rises;
endmodule

// file: output_clock_distribution_tb.sv
// self-checking bench for the output clock distribution block
// assumes clkdist_pkg and clk_receiver are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: value mismatch", $time); end end
module output_clock_distribution_tb;
  localparam int HALF [7] = '{2, 3, 4, 5, 6, 7, 8};
  logic clock, rst, pll_a_lock, pll_b_lock, pll_c_lock, sync_pin, sync_sw, sync_master_en;
  logic sel_ch4_7, sel_ch8_13, pll_c_post_bypass, aux_one_en, aux_two_en, aux_io_one, aux_io_one_oe;
  logic aux_io_two, aux_io_two_oe;
  logic [6:0]        src;
  logic [10:0]       div_sync_en, sysref_en, div_pwr_dn;
  logic [2:0]        sel_ch0, sel_ch1, aux_one_sel, aux_two_sel;
  logic [1:0]        sel_ch2_3, sel_ch14_15, cmos_mode;
  logic [10:0][11:0] chan_div_value;
  logic [10:0][19:0] sysref_div_value;
  logic [10:0][7:0]  static_dly, sysref_dly;
  logic [15:0][2:0]  out_fmt;
  logic [15:0]       mute_en, out_p, out_n, out_p_oe, out_n_oe;
  logic [1:0][1:0]   pol_p, pol_n;
  wire [6:0][15:0]   per, rises;
  logic [6:0]        probe;
  logic [15:0]       r0, r6;
  int                cyc, mismatches, n_tests;
  clkdist u_clkdist (.clock(clock), .rst(rst), .pll_c_clk(src[0]), .pll_b_clk(src[1]), .pll_a_clk(src[2]),
    .pll_a_sec_clk(src[3]), .crystal_ref_clk(src[4]), .ref_in_clk(src[5]), .osc_c_clk(src[6]),
    .pll_a_lock(pll_a_lock), .pll_b_lock(pll_b_lock), .pll_c_lock(pll_c_lock), .sync_pin(sync_pin),
    .sync_sw(sync_sw), .sync_master_en(sync_master_en), .div_sync_en(div_sync_en), .sel_ch0(sel_ch0),
    .sel_ch1(sel_ch1), .sel_ch2_3(sel_ch2_3), .sel_ch14_15(sel_ch14_15), .sel_ch4_7(sel_ch4_7),
    .sel_ch8_13(sel_ch8_13), .pll_c_post_bypass(pll_c_post_bypass), .chan_div_value(chan_div_value),
    .sysref_div_value(sysref_div_value), .sysref_en(sysref_en), .static_dly(static_dly),
    .sysref_dly(sysref_dly), .out_fmt(out_fmt), .mute_en(mute_en), .cmos_mode(cmos_mode), .pol_p(pol_p),
    .pol_n(pol_n), .aux_one_en(aux_one_en), .aux_one_sel(aux_one_sel), .aux_two_en(aux_two_en),
    .aux_two_sel(aux_two_sel), .out_p(out_p), .out_n(out_n), .out_p_oe(out_p_oe), .out_n_oe(out_n_oe),
    .aux_io_one(aux_io_one), .aux_io_one_oe(aux_io_one_oe), .aux_io_two(aux_io_two),
    .aux_io_two_oe(aux_io_two_oe), .div_pwr_dn(div_pwr_dn));
  assign probe = {out_p[1], aux_io_one, out_p[14], out_p[5], out_p[4], out_p[2], out_p[0]};
  for (genvar g = 0; g < 7; g++) begin : g_rx
    clk_receiver u_clk_receiver (.clock(clock), .rst(rst), .pin(probe[g]), .period(per[g]), .rises(rises[g]));
  end
  // ****************************************
  // clock and source clocks
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 7; i++) begin
      if (cyc % HALF[i] == 0) src[i] <= ~src[i];
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic per_chk(input int i, input int exp);
    wait_cyc(4 * exp + 12);
    `CHK(per[i], 16'(exp))
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    final_report();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst = 1'b1; cyc = 0; src = '0; mismatches = 0; n_tests = 0;
    {pll_a_lock, pll_b_lock, pll_c_lock} = 3'h7;
    {sync_pin, sync_sw, sync_master_en, pll_c_post_bypass, aux_one_en, aux_two_en} = '0;
    {sel_ch4_7, sel_ch8_13, sel_ch0, sel_ch1, sel_ch2_3, sel_ch14_15, cmos_mode} = '0;
    {aux_one_sel, aux_two_sel, sysref_en, static_dly, sysref_dly, mute_en} = '0;
    div_sync_en = 11'h7ff;
    chan_div_value = {11{12'h002}};
    sysref_div_value = '0;
    out_fmt = {16{clkdist_pkg::FMT_LVDS}};
    pol_p = '0;
    pol_n = {2{clkdist_pkg::POL_INV}};
    wait_cyc(6);
    rst <= 1'b0;
    chan_div_value[0] <= 12'h003;
    for (int s = 0; s < 6; s++) begin
      sel_ch0 <= 3'(s);
      per_chk(0, 6 * HALF[s]);
    end
    for (int s = 0; s < 4; s++) begin
      sel_ch2_3 <= 2'(s);
      per_chk(1, 4 * HALF[s == 3 ? 2 : s]);
    end
    chan_div_value[4] <= 12'h004;
    for (int s = 0; s < 2; s++) begin
      sel_ch4_7 <= 1'(s);
      per_chk(2, 8 * HALF[s]);
      `CHK(per[3], 16'(8 * HALF[s]))
    end
    sel_ch14_15 <= 2'h3;
    pll_c_post_bypass <= 1'b1;
    per_chk(4, 4 * HALF[6]);
    pll_c_post_bypass <= 1'b0;
    per_chk(4, 4 * HALF[0]);
    chan_div_value[0] <= 12'h002;
    sel_ch0 <= 3'h0;
    sysref_en <= 11'h011;
    sysref_div_value[0] <= 20'h00005;
    sysref_div_value[4] <= 20'h00003;
    aux_one_en <= 1'b1;
    per_chk(0, 40);
    `CHK(aux_io_one_oe, 1'b1)
    per_chk(5, 40);
    per_chk(2, 72);
    aux_one_sel <= 3'h2;
    per_chk(5, 72);
    sysref_en <= '0;
    aux_one_en <= 1'b0;
    out_fmt[4] <= clkdist_pkg::FMT_OFF;
    wait_cyc(5);
    `CHK(div_pwr_dn[4], 1'b0)
    out_fmt[5] <= clkdist_pkg::FMT_OFF;
    out_fmt[0] <= clkdist_pkg::FMT_OFF;
    out_fmt[9:8] <= {2{clkdist_pkg::FMT_OFF}};
    wait_cyc(5);
    `CHK(div_pwr_dn[4], 1'b1)
    `CHK(div_pwr_dn[6], 1'b1)
    `CHK(div_pwr_dn[0], 1'b1)
    out_fmt <= {16{clkdist_pkg::FMT_LVDS}};
    chan_div_value[0] <= 12'h004;
    chan_div_value[2] <= 12'h004;
    chan_div_value[1] <= 12'h001;
    chan_div_value[4] <= 12'h001;
    sel_ch2_3 <= 2'h0;
    sync_master_en <= 1'b1;
    sync_sw <= 1'b1;
    wait_cyc(10);
    r0 = rises[0];
    r6 = rises[6];
    wait_cyc(40);
    `CHK(rises[0], r0)
    `CHK(out_p[0], 1'b0)
    `CHK(rises[6] != r6, 1'b1)
    sync_sw <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      `CHK(out_p[2], out_p[0])
    end
    mute_en[3:2] <= 2'h3;
    pll_c_lock <= 1'b0;
    wait_cyc(10);
    r0 = rises[1];
    wait_cyc(40);
    `CHK(rises[1], r0)
    pll_c_lock <= 1'b1;
    cmos_mode <= 2'h1;
    wait_cyc(10);
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      #1 `CHK(out_n[0], ~out_p[0])
    end
    pol_n[0] <= clkdist_pkg::POL_HIZ;
    wait_cyc(5);
    `CHK(out_n_oe[0], 1'b0)
    pol_n[0] <= clkdist_pkg::POL_LOW;
    wait_cyc(5);
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      `CHK(out_n[0], 1'b0)
    end
    for (int f = 0; f < 5; f++) begin
      out_fmt[3] <= 3'(f);
      wait_cyc(4);
      `CHK(out_p_oe[3], 1'(f != 0))
    end
    final_report();
  end
endmodule
